/* File: design/tm8_cfg.svh */
// Purpose: register offsets, field positions and reset values of the 8-bit timer
// Assumes: byte-wide register port with a three-bit address
// Notes: definitions only
`ifndef TM8_CFG_SVH
`define TM8_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TM8_OFS_CTRL_A 3'h0
`define TM8_OFS_CTRL_B 3'h1
`define TM8_OFS_COUNT 3'h2
`define TM8_OFS_CMP_A 3'h3
`define TM8_OFS_CMP_B 3'h4
`define TM8_OFS_FLAGS 3'h5
`define TM8_OFS_PIN_DIR 3'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define TM8_CTRL_A_ACT_A 7:6
`define TM8_CTRL_A_ACT_B 5:4
`define TM8_CTRL_A_MODE_LO 1:0
`define TM8_CTRL_B_MODE_HI 3
`define TM8_CTRL_B_CLK_SEL 2:0
`define TM8_FLAG_OVF 0
`define TM8_FLAG_CMP_A 1
`define TM8_FLAG_CMP_B 2

// ----------------------------------------
// values and reset values
// ----------------------------------------
`define TM8_CNT_MAX 8'hff
`define TM8_CNT_BOTTOM 8'h00
`define TM8_RST_BYTE 8'h00
`define TM8_RST_BITS2 2'h0

`endif

/* File: design/tm8_pkg.sv */
// Purpose: types shared by the timer files
// Assumes: nothing
// Notes: numeric constants live in tm8_cfg.svh
package tm8_pkg;

   // binary order along normal -> phase correct -> ctc -> fast
   typedef enum logic [2:0] {
      TM8_NORMAL = 3'h0,
      TM8_PC_FULL = 3'h1,
      TM8_CTC = 3'h2,
      TM8_FAST_FULL = 3'h3,
      TM8_RSV4 = 3'h4,
      TM8_PC_CMPA = 3'h5,
      TM8_RSV6 = 3'h6,
      TM8_FAST_CMPA = 3'h7
   } tm8_mode_t;

   typedef enum logic {
      TM8_UP = 1'b0,
      TM8_DOWN = 1'b1
   } tm8_dir_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } tm8_bus_req_t;

   typedef struct packed {
      logic [1:0][1:0] output_action_sel;
      tm8_mode_t waveform_mode_sel;
      logic [2:0] clock_source_sel;
      logic [1:0] pin_dir;
   } tm8_ctrl_t;

endpackage : tm8_pkg

/* File: design/tm8_counter.sv */
// Purpose: counting sequence of the 8-bit timer
// Assumes: tick is a one-cycle enable from the same clock
// Notes: a software load wins over any count step
`include "tm8_cfg.svh"

module tm8_counter import tm8_pkg::*; (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic tick,
   input wire tm8_mode_t mode,
   input wire logic [7:0] top,
   input wire logic load,
   input wire logic [7:0] load_value,
   output logic [7:0] count_value,
   output tm8_dir_t dir
);

   logic [7:0] next_count;
   tm8_dir_t next_dir;
   logic at_top;
   logic is_pc;
   logic reserved;

   assign at_top = (count_value == top);
   assign is_pc = (mode == TM8_PC_FULL) || (mode == TM8_PC_CMPA);
   assign reserved = (mode == TM8_RSV4) || (mode == TM8_RSV6);

   always_comb begin
      next_count = count_value;
      next_dir = is_pc ? dir : TM8_UP;
      if (load) begin
         next_count = load_value; // R24
      end else if (tick && !reserved) begin // R26
         if (mode == TM8_NORMAL) begin
            next_count = count_value + 8'h01; // R1
         end else if (!is_pc) begin
            next_count = at_top ? `TM8_CNT_BOTTOM : count_value + 8'h01; // R4 R5 R9 R10
         end else if (dir == TM8_UP) begin
            // top is held for the one tick before the turn
            if (at_top) begin
               next_dir = TM8_DOWN; // R17
               next_count = count_value - 8'h01;
            end else begin
               next_count = count_value + 8'h01; // R16
            end
         end else if (count_value == `TM8_CNT_BOTTOM) begin
            next_dir = TM8_UP; // R16
            next_count = count_value + 8'h01;
         end else begin
            next_count = count_value - 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         count_value <= `TM8_RST_BYTE;
         dir <= TM8_UP;
      end else begin
         count_value <= next_count;
         dir <= next_dir;
      end
   end

endmodule : tm8_counter

/* File: design/tm8_cmp_buf.sv */
// Purpose: compare value with its double buffer
// Assumes: update is a one-cycle pulse at the reload point
// Notes: without pwm the write lands straight in the active value
`include "tm8_cfg.svh"

module tm8_cmp_buf (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic wr,
   input wire logic [7:0] wdata,
   input wire logic pwm,
   input wire logic update,
   output logic [7:0] active,
   output logic [7:0] buffered
);

   logic [7:0] next_active;
   logic [7:0] next_buffered;

   assign next_buffered = wr ? wdata : buffered;
   assign next_active = (wr && !pwm) ? wdata : // R5 R23
                        (pwm && update) ? buffered : active; // R15 R23

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         active <= `TM8_RST_BYTE;
         buffered <= `TM8_RST_BYTE;
      end else begin
         active <= next_active;
         buffered <= next_buffered;
      end
   end

endmodule : tm8_cmp_buf

/* File: design/tm8_waveform_modes.sv */
// Purpose: 8-bit timer with two compare channels and four waveform modes
// Assumes: tick_in is a prescaled enable from clk_sys; no pin inputs
// Notes: registers on a byte port, read data one cycle after the strobe
//
// Functional notes
// [R1] normal mode counts up without clear and wraps max to zero
// [R2] normal mode sets overflow flag when count becomes zero; counting never clears
// [R3] overflow flag clears when its interrupt is serviced
// [R4] mode 2 clears counter on compare A match; compare A is top
// [R5] clear-on-match compare unbuffered; value below count runs count through wrap
// [R6] clear-on-match sets overflow flag on max to zero
// [R7] clear-on-match with action 1 toggles output A on each match
// [R8] waveform reaches pin only while its direction bit selects output
// [R9] modes 3 and 7 are fast pwm, top max or compare A
// [R10] fast pwm counts to top then clears on next tick
// [R11] fast pwm action 2 clears on match, sets at bottom; 3 inverse
// [R12] fast pwm sets overflow flag each time counter reaches top
// [R13] pwm action 1 toggles output A on match only with mode bit two
// [R14] fast pwm compare zero gives spike, compare max constant level
// [R15] fast pwm compare values double-buffered, toggle action included
// [R16] modes 1 and 5 are phase-correct pwm, top max or compare A
// [R17] phase-correct reverses at top, holding top for one tick
// [R18] phase-correct clears on up match, sets on down match; inverting reversed
// [R19] phase-correct sets overflow flag each time counter reaches zero
// [R20] phase-correct compare zero holds low, max holds high; inverting opposite
// [R21] missed up match or leaving max forces up-match level at period start
// [R22] output actions never affect counting, only the waveforms
// [R23] pwm writes go to buffer loaded at top or bottom; others direct
// [R24] count write blocks next tick's match and beats clear or count
// [R25] match sets compare flag next tick; clock select zero stops ticks
// [R26] modes 4 and 6 reserved: counter and outputs stay frozen
`include "tm8_cfg.svh"

module tm8_waveform_modes import tm8_pkg::*; (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic tick_in,
   input wire logic ovf_service_ack,
   input wire logic cmp_a_service_ack,
   input wire tm8_bus_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic wave_out_a_pin,
   output logic wave_out_a_oe,
   output logic wave_out_b_pin,
   output logic wave_out_b_oe,
   output logic overflow_flag,
   output logic compare_a_flag,
   output logic compare_b_flag
);

   // ----------------------------------------
   // register decode
   // ----------------------------------------
   tm8_ctrl_t ctrl;
   logic wr_ctrl_a;
   logic wr_ctrl_b;
   logic wr_count;
   logic wr_flags;
   logic wr_pin_dir;
   logic [1:0] wr_cmp;

   assign wr_ctrl_a = reg_req.wr && (reg_req.addr == `TM8_OFS_CTRL_A);
   assign wr_ctrl_b = reg_req.wr && (reg_req.addr == `TM8_OFS_CTRL_B);
   assign wr_count = reg_req.wr && (reg_req.addr == `TM8_OFS_COUNT);
   assign wr_flags = reg_req.wr && (reg_req.addr == `TM8_OFS_FLAGS);
   assign wr_pin_dir = reg_req.wr && (reg_req.addr == `TM8_OFS_PIN_DIR);
   assign wr_cmp[0] = reg_req.wr && (reg_req.addr == `TM8_OFS_CMP_A);
   assign wr_cmp[1] = reg_req.wr && (reg_req.addr == `TM8_OFS_CMP_B);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctrl.output_action_sel <= {`TM8_RST_BITS2, `TM8_RST_BITS2};
         ctrl.waveform_mode_sel <= TM8_NORMAL;
         ctrl.clock_source_sel <= 3'h0;
         ctrl.pin_dir <= `TM8_RST_BITS2;
      end else begin
         if (wr_ctrl_a) begin
            ctrl.output_action_sel[0] <= reg_req.wdata[`TM8_CTRL_A_ACT_A];
            ctrl.output_action_sel[1] <= reg_req.wdata[`TM8_CTRL_A_ACT_B];
            ctrl.waveform_mode_sel <=
               tm8_mode_t'({ctrl.waveform_mode_sel[2], reg_req.wdata[`TM8_CTRL_A_MODE_LO]});
         end
         if (wr_ctrl_b) begin
            ctrl.waveform_mode_sel <=
               tm8_mode_t'({reg_req.wdata[`TM8_CTRL_B_MODE_HI], ctrl.waveform_mode_sel[1:0]});
            ctrl.clock_source_sel <= reg_req.wdata[`TM8_CTRL_B_CLK_SEL];
         end
         if (wr_pin_dir) begin
            ctrl.pin_dir <= reg_req.wdata[1:0];
         end
      end
   end

   // ----------------------------------------
   // mode decode and timer tick
   // ----------------------------------------
   tm8_mode_t mode;
   logic mode_bit_two;
   logic is_fast;
   logic is_pc;
   logic is_plain;
   logic reserved;
   logic tick;
   logic tick_run;

   assign mode = ctrl.waveform_mode_sel;
   assign mode_bit_two = mode[2];
   assign is_fast = (mode == TM8_FAST_FULL) || (mode == TM8_FAST_CMPA); // R9
   assign is_pc = (mode == TM8_PC_FULL) || (mode == TM8_PC_CMPA); // R16
   assign is_plain = (mode == TM8_NORMAL) || (mode == TM8_CTC);
   assign reserved = (mode == TM8_RSV4) || (mode == TM8_RSV6);
   // prescaler lives outside; a zero clock select stops everything
   assign tick = tick_in && (ctrl.clock_source_sel != 3'h0); // R25
   assign tick_run = tick && !reserved && !wr_count; // R24 R26

   // ----------------------------------------
   // counter and compare values
   // ----------------------------------------
   logic [7:0] count_value;
   tm8_dir_t dir;
   logic [7:0] top;
   logic [1:0][7:0] cmp_active;
   logic [1:0][7:0] cmp_buffered;
   logic at_top;
   logic top_ev;
   logic bottom_ev;
   tm8_mode_t cnt_mode;

   // output actions do not enter the counter at all
   assign top = ((mode == TM8_CTC) || (mode == TM8_FAST_CMPA) || (mode == TM8_PC_CMPA))
      ? cmp_active[0] : `TM8_CNT_MAX; // R4 R9 R16 R22
   assign at_top = (count_value == top);
   assign top_ev = tick_run && at_top && (is_fast || (is_pc && dir == TM8_UP));
   assign bottom_ev = tick_run && is_pc && (dir == TM8_DOWN)
      && (count_value == `TM8_CNT_BOTTOM);

   tm8_counter u_counter (
      .clk_sys(clk_sys),
      .srst(srst),
      .tick(tick),
      .mode(cnt_mode),
      .top(top),
      .load(wr_count),
      .load_value(reg_req.wdata),
      .count_value(count_value),
      .dir(dir)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cmp
         tm8_cmp_buf u_cmp (
            .clk_sys(clk_sys),
            .srst(srst),
            .wr(wr_cmp[gi]),
            .wdata(reg_req.wdata),
            .pwm(is_fast || is_pc),
            .update(top_ev), // R23
            .active(cmp_active[gi]),
            .buffered(cmp_buffered[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // match blocking after a count write
   // ----------------------------------------
   // even a stopped timer remembers the write until its next tick
   logic match_block;
   logic next_match_block;

   assign next_match_block = wr_count ? 1'b1 : (tick ? 1'b0 : match_block); // R24
   // the ctc clear is a match, so a blocked tick just counts on
   assign cnt_mode = (mode == TM8_CTC && match_block) ? TM8_NORMAL : mode; // R24

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         match_block <= 1'b0;
      end else begin
         match_block <= next_match_block;
      end
   end

   // ----------------------------------------
   // waveform generation per channel
   // ----------------------------------------
   logic [1:0] match;
   logic [1:0] wave;
   logic [1:0] next_wave;
   logic [1:0] up_seen;
   logic [1:0] next_up_seen;

   generate
      for (gi = 0; gi < 2; gi++) begin : g_wave
         logic [1:0] act;
         logic cmp_is_top;
         logic toggle_ok;

         assign act = ctrl.output_action_sel[gi];
         assign cmp_is_top = (cmp_active[gi] == top);
         // toggle in pwm modes exists on channel A only
         assign toggle_ok = (gi == 0) && mode_bit_two && (act == 2'h1); // R13
         assign match[gi] = tick_run && !match_block
            && (count_value == cmp_active[gi]); // R24

         always_comb begin
            next_wave[gi] = wave[gi];
            if (is_fast) begin
               if (act[1]) begin
                  if (match[gi] && !cmp_is_top) begin
                     next_wave[gi] = act[0]; // R11
                  end
                  if (top_ev) begin
                     next_wave[gi] = !act[0]; // R11 R14
                  end
               end else if (toggle_ok && match[gi]) begin
                  next_wave[gi] = !wave[gi]; // R13 R15
               end
            end else if (is_pc) begin
               if (act[1]) begin
                  if (match[gi] && !cmp_is_top) begin
                     next_wave[gi] = (dir == TM8_UP) ? act[0] : !act[0]; // R18
                  end
                  if (top_ev && cmp_is_top) begin
                     next_wave[gi] = !act[0]; // R20
                  end
                  // restore symmetry when the up-slope match never came
                  if (bottom_ev && !up_seen[gi] && !cmp_is_top) begin
                     next_wave[gi] = act[0]; // R20 R21
                  end
               end else if (toggle_ok && match[gi]) begin
                  next_wave[gi] = !wave[gi]; // R13
               end
            end else if (is_plain && match[gi]) begin
               unique case (act)
                  2'h0: next_wave[gi] = wave[gi];
                  2'h1: next_wave[gi] = !wave[gi]; // R7
                  2'h2: next_wave[gi] = 1'b0;
                  2'h3: next_wave[gi] = 1'b1;
               endcase
            end
         end

         assign next_up_seen[gi] = bottom_ev ? 1'b0 :
            ((match[gi] && dir == TM8_UP) ? 1'b1 : up_seen[gi]); // R21
      end
   endgenerate

   // output state survives mode changes; only reset clears it
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wave <= `TM8_RST_BITS2;
         up_seen <= `TM8_RST_BITS2;
      end else begin
         wave <= next_wave;
         up_seen <= next_up_seen;
      end
   end

   // ----------------------------------------
   // flags
   // ----------------------------------------
   logic ovf_set;
   logic ovf_clr;
   logic cmp_a_clr;
   logic cmp_b_clr;
   logic next_ovf;
   logic next_cmp_a;
   logic next_cmp_b;

   assign ovf_set = tick_run && (
      (is_plain && count_value == `TM8_CNT_MAX) || // R2 R6
      (is_fast && at_top) || // R12
      (is_pc && dir == TM8_DOWN && count_value == 8'h01)); // R19
   assign ovf_clr = ovf_service_ack || (wr_flags && reg_req.wdata[`TM8_FLAG_OVF]); // R3
   assign cmp_a_clr = cmp_a_service_ack || (wr_flags && reg_req.wdata[`TM8_FLAG_CMP_A]);
   assign cmp_b_clr = wr_flags && reg_req.wdata[`TM8_FLAG_CMP_B];
   // a set in the clearing cycle wins
   assign next_ovf = ovf_set || (overflow_flag && !ovf_clr); // R2
   assign next_cmp_a = match[0] || (compare_a_flag && !cmp_a_clr); // R25
   assign next_cmp_b = match[1] || (compare_b_flag && !cmp_b_clr); // R25

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         overflow_flag <= 1'b0;
         compare_a_flag <= 1'b0;
         compare_b_flag <= 1'b0;
      end else begin
         overflow_flag <= next_ovf;
         compare_a_flag <= next_cmp_a;
         compare_b_flag <= next_cmp_b;
      end
   end

   // ----------------------------------------
   // pins
   // ----------------------------------------
   // an action of zero disconnects the waveform; the pin then drives low
   logic next_pin_a;
   logic next_pin_b;

   assign next_pin_a = (ctrl.output_action_sel[0] != 2'h0) && wave[0];
   assign next_pin_b = (ctrl.output_action_sel[1] != 2'h0) && wave[1];

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wave_out_a_pin <= 1'b0;
         wave_out_b_pin <= 1'b0;
         wave_out_a_oe <= 1'b0;
         wave_out_b_oe <= 1'b0;
      end else begin
         wave_out_a_pin <= next_pin_a;
         wave_out_b_pin <= next_pin_b;
         wave_out_a_oe <= ctrl.pin_dir[0]; // R8
         wave_out_b_oe <= ctrl.pin_dir[1]; // R8
      end
   end

   // ----------------------------------------
   // read back
   // ----------------------------------------
   logic pwm_buffered;
   logic [7:0] rd_mux;

   // in pwm modes software sees the buffer, not the active value
   assign pwm_buffered = is_fast || is_pc;
   assign rd_mux =
      (reg_req.addr == `TM8_OFS_CTRL_A) ?
         {ctrl.output_action_sel[0], ctrl.output_action_sel[1], 2'h0, mode[1:0]} :
      (reg_req.addr == `TM8_OFS_CTRL_B) ? {4'h0, mode[2], ctrl.clock_source_sel} :
      (reg_req.addr == `TM8_OFS_COUNT) ? count_value :
      (reg_req.addr == `TM8_OFS_CMP_A) ?
         (pwm_buffered ? cmp_buffered[0] : cmp_active[0]) :
      (reg_req.addr == `TM8_OFS_CMP_B) ?
         (pwm_buffered ? cmp_buffered[1] : cmp_active[1]) :
      (reg_req.addr == `TM8_OFS_FLAGS) ?
         {5'h0, compare_b_flag, compare_a_flag, overflow_flag} :
      (reg_req.addr == `TM8_OFS_PIN_DIR) ? {6'h0, ctrl.pin_dir} :
      8'h00;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         reg_rdata <= `TM8_RST_BYTE;
      end else begin
         reg_rdata <= reg_req.rd ? rd_mux : 8'h00;
      end
   end

endmodule : tm8_waveform_modes

/* File: sim/tm8_pin_load.sv */
// Purpose: external load on the two waveform pins
// Assumes: each pin carries a weak pull-down on the board
// Notes: level is what a device on the pin would see
module tm8_pin_load (
   input wire logic [1:0] pin,
   input wire logic [1:0] oe,
   output logic [1:0] level
);
   timeunit 1ns;
   timeprecision 1ps;

   // a released pin falls to the pull-down, never keeps the last value
   assign level = oe & pin;
endmodule : tm8_pin_load

/* File: sim/tm8_waveform_modes_props.sv */
// Purpose: port-level checks on the timer flags and pin enables
// Assumes: single clock, synchronous active-high reset
// Notes: attached by the bind below the module
`include "tm8_cfg.svh"

module tm8_waveform_modes_props import tm8_pkg::*; (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic tick_in,
   input wire logic ovf_service_ack,
   input wire logic cmp_a_service_ack,
   input wire tm8_bus_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic wave_out_a_pin,
   input wire logic wave_out_a_oe,
   input wire logic wave_out_b_pin,
   input wire logic wave_out_b_oe,
   input wire logic overflow_flag,
   input wire logic compare_a_flag,
   input wire logic compare_b_flag
);
   timeunit 1ns;
   timeprecision 1ps;

   logic flag_wr;
   assign flag_wr = reg_req.wr && (reg_req.addr == `TM8_OFS_FLAGS);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_ovf_sticky: assert property (
      overflow_flag && !ovf_service_ack && !(flag_wr && reg_req.wdata[`TM8_FLAG_OVF])
      |=> overflow_flag) else $error("overflow flag dropped without a clear");
   a_cmpa_sticky: assert property (
      compare_a_flag && !cmp_a_service_ack && !(flag_wr && reg_req.wdata[`TM8_FLAG_CMP_A])
      |=> compare_a_flag) else $error("compare A flag dropped without a clear");
   a_cmpb_sticky: assert property (
      compare_b_flag && !(flag_wr && reg_req.wdata[`TM8_FLAG_CMP_B])
      |=> compare_b_flag) else $error("compare B flag dropped without a clear");
   a_ovf_ack_clear: assert property (
      ovf_service_ack && !tick_in |=> !overflow_flag)
      else $error("overflow flag survived its service");
   a_cmpa_ack_clear: assert property (
      cmp_a_service_ack && !tick_in |=> !compare_a_flag)
      else $error("compare A flag survived its service");
   a_ovf_on_tick: assert property (
      $rose(overflow_flag) |-> $past(tick_in))
      else $error("overflow flag rose without a tick");
   a_cmp_on_tick: assert property (
      $rose(compare_a_flag) || $rose(compare_b_flag) |-> $past(tick_in))
      else $error("compare flag rose without a tick");
   a_oe_follow: assert property (
      reg_req.wr && reg_req.addr == `TM8_OFS_PIN_DIR ##1 !reg_req.wr
      |-> ##1 {wave_out_b_oe, wave_out_a_oe} == $past(reg_req.wdata[1:0], 2))
      else $error("pin enables differ from direction bits");
endmodule : tm8_waveform_modes_props

bind tm8_waveform_modes tm8_waveform_modes_props u_props (
   .clk_sys(clk_sys), .srst(srst), .tick_in(tick_in),
   .ovf_service_ack(ovf_service_ack), .cmp_a_service_ack(cmp_a_service_ack),
   .reg_req(reg_req), .reg_rdata(reg_rdata),
   .wave_out_a_pin(wave_out_a_pin), .wave_out_a_oe(wave_out_a_oe),
   .wave_out_b_pin(wave_out_b_pin), .wave_out_b_oe(wave_out_b_oe),
   .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag),
   .compare_b_flag(compare_b_flag)
);

/* File: sim/tb_tm8_waveform_modes.sv */
// Purpose: self-checking bench for the timer waveform modes
// Assumes: tick_in held high one clock per timer tick
// Notes: each table row restarts the timer from reset
`include "tm8_cfg.svh"

`define TM8_CHK(got, exp) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      num_errors++; \
      $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
   end \
end

module tb_tm8_waveform_modes import tm8_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   // cf of 2 leaves the compare flag unchecked
   typedef struct packed {
      logic [2:0] mode;
      logic [1:0] act;
      logic [7:0] cmp;
      logic [7:0] start;
      logic [9:0] n;
      logic [7:0] cnt;
      logic ovf;
      logic pin;
      logic [1:0] cf;
   } tm8_tb_row_t;

   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic tick_in = 1'b0;
   logic ovf_service_ack = 1'b0;
   logic cmp_a_service_ack = 1'b0;
   tm8_bus_req_t reg_req = '0;
   logic [7:0] reg_rdata;
   logic wave_out_a_pin;
   logic wave_out_a_oe;
   logic wave_out_b_pin;
   logic wave_out_b_oe;
   logic overflow_flag;
   logic compare_a_flag;
   logic compare_b_flag;
   logic [1:0] pin_level;
   int num_errors = 0;
   int checks_done = 0;

   tm8_tb_row_t rows [18] = '{
      '{3'h0, 2'h0, 8'h10, 8'h00, 10'h100, 8'h00, 1'h1, 1'h0, 2'h1},
      '{3'h2, 2'h1, 8'h03, 8'h00, 10'h006, 8'h02, 1'h0, 1'h1, 2'h1},
      '{3'h2, 2'h0, 8'h03, 8'h10, 10'h0f4, 8'h00, 1'h1, 1'h0, 2'h1},
      '{3'h2, 2'h1, 8'h05, 8'h05, 10'h001, 8'h06, 1'h0, 1'h0, 2'h0},
      '{3'h3, 2'h2, 8'h80, 8'h00, 10'h12c, 8'h2c, 1'h1, 1'h1, 2'h1},
      '{3'h3, 2'h3, 8'h80, 8'h00, 10'h12c, 8'h2c, 1'h1, 1'h0, 2'h1},
      '{3'h3, 2'h1, 8'h80, 8'h00, 10'h12c, 8'h2c, 1'h1, 1'h0, 2'h1},
      '{3'h7, 2'h1, 8'h05, 8'h00, 10'h008, 8'h02, 1'h1, 1'h1, 2'h1},
      '{3'h3, 2'h2, 8'h00, 8'h00, 10'h100, 8'h00, 1'h1, 1'h1, 2'h0},
      '{3'h3, 2'h2, 8'h00, 8'h00, 10'h101, 8'h01, 1'h1, 1'h0, 2'h1},
      '{3'h3, 2'h2, 8'hff, 8'h00, 10'h12c, 8'h2c, 1'h1, 1'h1, 2'h2},
      '{3'h1, 2'h2, 8'h80, 8'h00, 10'h190, 8'h6e, 1'h0, 1'h1, 2'h1},
      '{3'h1, 2'h3, 8'h80, 8'h00, 10'h1fe, 8'h00, 1'h1, 1'h0, 2'h1},
      '{3'h5, 2'h0, 8'h04, 8'h00, 10'h008, 8'h00, 1'h1, 1'h0, 2'h2},
      '{3'h1, 2'h2, 8'h00, 8'h00, 10'h190, 8'h6e, 1'h0, 1'h0, 2'h2},
      '{3'h1, 2'h2, 8'hff, 8'h00, 10'h190, 8'h6e, 1'h0, 1'h1, 2'h2},
      '{3'h1, 2'h2, 8'h10, 8'h20, 10'h1e5, 8'h07, 1'h1, 1'h0, 2'h1},
      '{3'h4, 2'h2, 8'h10, 8'h20, 10'h00a, 8'h20, 1'h0, 1'h0, 2'h0}
   };

   always #50 clk_sys = ~clk_sys;

   tm8_waveform_modes uut (
      .clk_sys(clk_sys), .srst(srst), .tick_in(tick_in),
      .ovf_service_ack(ovf_service_ack), .cmp_a_service_ack(cmp_a_service_ack),
      .reg_req(reg_req), .reg_rdata(reg_rdata),
      .wave_out_a_pin(wave_out_a_pin), .wave_out_a_oe(wave_out_a_oe),
      .wave_out_b_pin(wave_out_b_pin), .wave_out_b_oe(wave_out_b_oe),
      .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag),
      .compare_b_flag(compare_b_flag)
   );

   tm8_pin_load u_load (
      .pin({wave_out_b_pin, wave_out_a_pin}),
      .oe({wave_out_b_oe, wave_out_a_oe}),
      .level(pin_level)
   );

   // ----------------------------------------
   // bus and tick drivers
   // ----------------------------------------
   task wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      reg_req <= '0;
   endtask : wr_reg

   task rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      reg_req <= '0;
      #1 d = reg_rdata;
   endtask : rd_reg

   // two spare clocks let the pin register follow the last tick
   task ticks(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         tick_in <= 1'b1;
      end
      @(posedge clk_sys);
      tick_in <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : ticks

   // compare A written before and after the mode, compare B before it, so both copies agree
   task setup(input logic [2:0] m, input logic [1:0] a, input logic [7:0] c,
              input logic [7:0] s);
      @(posedge clk_sys);
      srst <= 1'b1;
      @(posedge clk_sys);
      srst <= 1'b0;
      wr_reg(`TM8_OFS_CMP_A, c);
      wr_reg(`TM8_OFS_CMP_B, c);
      wr_reg(`TM8_OFS_COUNT, s);
      wr_reg(`TM8_OFS_PIN_DIR, 8'h03);
      wr_reg(`TM8_OFS_CTRL_B, {4'h0, m[2], 3'h1});
      wr_reg(`TM8_OFS_CTRL_A, {a, a, 2'h0, m[1:0]});
      wr_reg(`TM8_OFS_CMP_A, c);
   endtask : setup

   task results;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results

   initial begin
      repeat (100000) @(posedge clk_sys);
      num_errors++;
      $display("Error at %0t: run timed out", $time);
      results();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      tm8_tb_row_t r;
      logic [7:0] d;
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      for (int a = 0; a < 8; a++) begin
         rd_reg(3'(a), d);
         `TM8_CHK(d, 8'h00)
      end
      ticks(5);
      rd_reg(`TM8_OFS_COUNT, d);
      `TM8_CHK(d, 8'h00)
      $display("reset test done");
      for (int i = 0; i < 18; i++) begin
         r = rows[i];
         setup(r.mode, r.act, r.cmp, r.start);
         ticks(int'(r.n));
         rd_reg(`TM8_OFS_COUNT, d);
         `TM8_CHK(d, r.cnt)
         `TM8_CHK(overflow_flag, r.ovf)
         `TM8_CHK(pin_level[0], r.pin)
         if (r.cf != 2'h2) `TM8_CHK(compare_a_flag, r.cf[0])
         if (r.cf != 2'h2) `TM8_CHK(compare_b_flag, r.cf[0])
         `TM8_CHK(pin_level[1], r.pin & ~(r.act == 2'h1 & r.mode[0]))
         @(posedge clk_sys);
         ovf_service_ack <= 1'b1;
         cmp_a_service_ack <= 1'b1;
         @(posedge clk_sys);
         ovf_service_ack <= 1'b0;
         cmp_a_service_ack <= 1'b0;
         @(posedge clk_sys);
         #1;
         `TM8_CHK({overflow_flag, compare_a_flag}, 2'h0)
         $display("row %0d done", i);
      end
      // new compare must wait for the top of the count
      setup(3'h3, 2'h2, 8'h80, 8'h00);
      ticks(16);
      wr_reg(`TM8_OFS_CMP_A, 8'h20);
      rd_reg(`TM8_OFS_CMP_A, d);
      `TM8_CHK(d, 8'h20)
      ticks(32);
      `TM8_CHK(compare_a_flag, 1'b0)
      ticks(224);
      `TM8_CHK(pin_level[0], 1'b1)
      wr_reg(`TM8_OFS_PIN_DIR, 8'h00);
      repeat (2) @(posedge clk_sys);
      #1;
      `TM8_CHK({wave_out_a_oe, pin_level[0]}, 2'h0)
      wr_reg(`TM8_OFS_PIN_DIR, 8'h03);
      ticks(32);
      `TM8_CHK(pin_level[0], 1'b0)
      $display("buffer test done");
      results();
   end
endmodule : tb_tm8_waveform_modes
